//--- hdl/ddsc_pkg.sv
// Package for the DDS core: register map, fields, reset values, constants.
// Assumes a 32-bit APB master and a single 40 MHz system clock.
package ddsc_pkg;
  localparam int ACC_W = 32;
  localparam int PHASE_W = 16;
  localparam int AMP_W = 14;
  localparam int DAC_W = 14;
  localparam int AUX_W = 8;
  localparam int SIN_W = 16;
  localparam int LUT_BITS = 8;
  localparam int NTAPS = 7;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FREQ = 12'h004;
  localparam logic [11:0] ADDR_PHASE = 12'h008;
  localparam logic [11:0] ADDR_AMP = 12'h00C;
  localparam logic [11:0] ADDR_AUX = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;

  localparam int CTRL_SINE_BIT = 16;
  localparam int CTRL_ISINC_BIT = 22;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FREQ_RST = 32'h0000_0000;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [13:0] AMP_RST = 14'h3FFF;
  localparam logic [7:0] AUX_RST = 8'h7F;

  localparam logic [1:0] MOD_DIV = 2'h3;

  localparam logic signed [15:0] TAP_OUT = -16'sd35;
  localparam logic signed [15:0] TAP_MID = 16'sd134;
  localparam logic signed [15:0] TAP_IN = -16'sd562;
  localparam logic signed [15:0] TAP_CTR = 16'sd6729;
  localparam int FIR_SHIFT = 13;
  localparam int FIR_SUM_W = 32;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] freq;
    logic [15:0] phase;
    logic [13:0] amp;
    logic [7:0] aux;
  } ddsc_regs_t;

  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic [13:0] amp;
  } ddsc_param_t;

  typedef struct packed {
    logic valid;
    logic [13:0] data;
  } ddsc_word_t;
endpackage

//--- hdl/ddsc_core.sv
// DDS core: APB registers, phase accumulator, sine lookup, amplitude
// scaling, optional inverse-sinc FIR and a two-entry output buffer.
// Assumes APB master on mclk; the DAC side may stall through dacReady.
// Contract
// - Output cosine by default; sine when the sine-select control bit is set.
// - Output frequency is tuning word over two to the 32 times clock.
// - Any 32-bit tuning word accepted unclamped; high words alias.
// - 16-bit phase offset added before amplitude lookup, spanning one cycle.
// - Lookup result multiplied by 14-bit amplitude scale over two to the 14.
// - Modulated parameter updates taken at most one in four clocks.
// - One 14-bit sample word per clock delivered toward the converter.
// - Hold 8-bit full-scale current code, initialised to 127.
// - Compensation filter active only when its enable bit is set.
// - Filter is 7-tap symmetric: -35, +134, -562, +6729 centre.
// - Filter sits after amplitude scaling, directly before the converter.
// - Filtered level is about 3 dB below the unfiltered level.
`timescale 1ns/1ps
module ddsc_core (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [13:0] dacData,
  output logic dacValid,
  input wire logic dacReady,
  output logic [7:0] fullScaleCode
);
  typedef struct packed {
    ddsc_pkg::ddsc_regs_t regs;
    ddsc_pkg::ddsc_param_t act;
    logic [1:0] modCnt;
    logic [31:0] acc;
    logic [15:0] phaseSum;
    logic sineSel;
    logic signed [15:0] wave;
    logic signed [15:0] scaled;
    logic [6:0][15:0] tapLine;
    logic [13:0] outWord;
    ddsc_pkg::ddsc_word_t buf0;
    ddsc_pkg::ddsc_word_t buf1;
    logic [31:0] rdata;
    logic slverr;
  } ddsc_state_t;

  ddsc_state_t st_ff;
  ddsc_state_t nxt_st;

  // Quarter-wave table, 256 points of a cosine quadrant, 16-bit signed
  function automatic logic signed [15:0] quarterCos(input logic [7:0] idx);
    real unused;
    logic [15:0] v;
    begin
      unused = 0.0;
      v = 16'h7FFF - ((16'h0 + idx) * (16'h0 + idx) >> 1);
      quarterCos = $signed(v);
    end
  endfunction

  // Full cosine from a 10-bit angle using quadrant symmetry
  function automatic logic signed [15:0] cosLookup(input logic [9:0] ang);
    logic [7:0] idx;
    logic signed [15:0] q;
    begin
      idx = ang[8] ? ~ang[7:0] : ang[7:0];
      q = quarterCos(idx);
      cosLookup = (ang[9] ^ ang[8]) ? -q : q;
    end
  endfunction

  function automatic logic isAddr(input logic [11:0] a,
                                  input logic [11:0] ref_a);
    begin
      isAddr = (a == ref_a);
    end
  endfunction

  // Decoded only in setup for the error flag; writes in access decode with isAddr
  function automatic logic isMapped(input logic [11:0] a);
    begin
      isMapped = isAddr(a, ddsc_pkg::ADDR_CTRL)
              || isAddr(a, ddsc_pkg::ADDR_FREQ)
              || isAddr(a, ddsc_pkg::ADDR_PHASE)
              || isAddr(a, ddsc_pkg::ADDR_AMP)
              || isAddr(a, ddsc_pkg::ADDR_AUX)
              || isAddr(a, ddsc_pkg::ADDR_STATUS);
    end
  endfunction

  logic apbWrite;
  logic apbRead;
  logic apbSetup;
  logic signed [15:0] tapS [0:6];
  logic signed [31:0] pairOut;
  logic signed [31:0] pairMid;
  logic signed [31:0] pairIn;
  logic signed [31:0] ctrTerm;
  logic signed [31:0] firSum;
  logic signed [31:0] firRound;
  logic signed [31:0] prod;
  logic [9:0] angle;
  logic bufPush;
  logic bufPop;
  logic signed [15:0] firOut;

  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !penable && !pwrite;
  assign apbSetup = psel && !penable;

  always_comb begin
    nxt_st = st_ff;
    firSum = 32'sh0;
    firRound = 32'sh0;
    prod = 32'sh0;
    angle = 10'h000;
    firOut = 16'sh0;
    bufPush = 1'b0;
    bufPop = 1'b0;
    pairOut = 32'sh0;
    pairMid = 32'sh0;
    pairIn = 32'sh0;
    ctrTerm = 32'sh0;
    for (int i = 0; i < ddsc_pkg::NTAPS; i++) begin
      tapS[i] = $signed(st_ff.tapLine[i]);
    end

    // Error decided in setup so it stands through the whole access phase
    if (apbSetup) begin
      nxt_st.slverr = !isMapped(paddr);
    end

    // Register writes take effect in the access cycle
    if (apbWrite) begin
      if (isAddr(paddr, ddsc_pkg::ADDR_CTRL)) begin
        nxt_st.regs.ctrl = pwdata;
      end else if (isAddr(paddr, ddsc_pkg::ADDR_FREQ)) begin
        nxt_st.regs.freq = pwdata;
      end else if (isAddr(paddr, ddsc_pkg::ADDR_PHASE)) begin
        nxt_st.regs.phase = pwdata[15:0];
      end else if (isAddr(paddr, ddsc_pkg::ADDR_AMP)) begin
        nxt_st.regs.amp = pwdata[13:0];
      end else if (isAddr(paddr, ddsc_pkg::ADDR_AUX)) begin
        nxt_st.regs.aux = pwdata[7:0];
      end
    end
    if (apbRead) begin
      nxt_st.rdata = 32'h0000_0000;
      if (isAddr(paddr, ddsc_pkg::ADDR_CTRL)) begin
        nxt_st.rdata = st_ff.regs.ctrl;
      end else if (isAddr(paddr, ddsc_pkg::ADDR_FREQ)) begin
        nxt_st.rdata = st_ff.regs.freq;
      end else if (isAddr(paddr, ddsc_pkg::ADDR_PHASE)) begin
        nxt_st.rdata = {16'h0000, st_ff.regs.phase};
      end else if (isAddr(paddr, ddsc_pkg::ADDR_AMP)) begin
        nxt_st.rdata = {18'h00000, st_ff.regs.amp};
      end else if (isAddr(paddr, ddsc_pkg::ADDR_AUX)) begin
        nxt_st.rdata = {24'h000000, st_ff.regs.aux};
      end else if (isAddr(paddr, ddsc_pkg::ADDR_STATUS)) begin
        // Live accumulator phase shows the core running
        nxt_st.rdata = st_ff.acc;
      end
    end

    // Parameters sampled once every four clocks bound the modulation rate
    nxt_st.modCnt = st_ff.modCnt + 2'h1;
    if (st_ff.modCnt == ddsc_pkg::MOD_DIV) begin
      nxt_st.act.freq = st_ff.regs.freq;
      nxt_st.act.phase = st_ff.regs.phase;
      nxt_st.act.amp = st_ff.regs.amp;
    end

    nxt_st.acc = st_ff.acc + st_ff.act.freq;
    nxt_st.phaseSum = st_ff.acc[31:16] + st_ff.act.phase;
    nxt_st.sineSel = st_ff.regs.ctrl[ddsc_pkg::CTRL_SINE_BIT];

    // Sine is cosine delayed a quarter turn
    angle = st_ff.phaseSum[15:6];
    if (st_ff.sineSel) begin
      angle = angle - 10'h100;
    end
    nxt_st.wave = cosLookup(angle);

    prod = st_ff.wave * $signed({2'b00, st_ff.act.amp});
    nxt_st.scaled = prod[29:14];

    // Delay line fed after scaling; the filter is the last stage
    nxt_st.tapLine[0] = st_ff.scaled;
    for (int i = 1; i < ddsc_pkg::NTAPS; i++) begin
      nxt_st.tapLine[i] = st_ff.tapLine[i-1];
    end
    // Symmetric pairs share one multiplier each
    pairOut = ddsc_pkg::TAP_OUT * (32'(tapS[0]) + 32'(tapS[6]));
    pairMid = ddsc_pkg::TAP_MID * (32'(tapS[1]) + 32'(tapS[5]));
    pairIn = ddsc_pkg::TAP_IN * (32'(tapS[2]) + 32'(tapS[4]));
    ctrTerm = ddsc_pkg::TAP_CTR * 32'(tapS[3]);
    firSum = pairOut + pairMid + pairIn + ctrTerm;
    // Gain 5803/8192 gives the insertion loss that keeps peaks in range
    firRound = (firSum + (32'sh1 <<< (ddsc_pkg::FIR_SHIFT - 1)))
               >>> ddsc_pkg::FIR_SHIFT;
    if (firRound > 32'sh7FFF) begin
      firOut = 16'sh7FFF;
    end else if (firRound < -32'sh8000) begin
      firOut = -16'sh8000;
    end else begin
      firOut = firRound[15:0];
    end
    if (st_ff.regs.ctrl[ddsc_pkg::CTRL_ISINC_BIT]) begin
      nxt_st.outWord = firOut[15:2];
    end else begin
      nxt_st.outWord = st_ff.scaled[15:2];
    end

    // Two-entry buffer; a sample is dropped at the source only when full
    bufPop = st_ff.buf0.valid && dacReady;
    bufPush = !st_ff.buf1.valid || bufPop;
    if (bufPop) begin
      nxt_st.buf0 = st_ff.buf1;
      nxt_st.buf1.valid = 1'b0;
    end
    if (bufPush) begin
      if (!nxt_st.buf0.valid) begin
        nxt_st.buf0.valid = 1'b1;
        nxt_st.buf0.data = st_ff.outWord;
      end else begin
        nxt_st.buf1.valid = 1'b1;
        nxt_st.buf1.data = st_ff.outWord;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.regs.ctrl <= ddsc_pkg::CTRL_RST;
      st_ff.regs.freq <= ddsc_pkg::FREQ_RST;
      st_ff.regs.phase <= ddsc_pkg::PHASE_RST;
      st_ff.regs.amp <= ddsc_pkg::AMP_RST;
      st_ff.regs.aux <= ddsc_pkg::AUX_RST;
      st_ff.act.amp <= ddsc_pkg::AMP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = st_ff.slverr && psel && penable;
  assign dacData = st_ff.buf0.data;
  assign dacValid = st_ff.buf0.valid;
  assign fullScaleCode = st_ff.regs.aux;
endmodule

//--- sim/ddsc_monitor.sv
// Port checker for the DDS core.
// Bound to every ddsc_core instance below.
`timescale 1ns/1ps
module ddsc_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [13:0] dacData,
  input wire logic dacValid,
  input wire logic dacReady,
  input wire logic [7:0] fullScaleCode
);
  logic wrAcc;
  logic [7:0] lowByte;
  logic muted_ff;
  logic nxt_muted;
  assign wrAcc = psel && penable && pwrite;
  assign lowByte = pwdata[7:0];
  // Zero scale must flush to zero words
  always_comb begin
    nxt_muted = muted_ff;
    if (wrAcc && paddr == ddsc_pkg::ADDR_AMP) begin
      nxt_muted = pwdata[13:0] == 14'h0000;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      muted_ff <= 1'b0;
    end else begin
      muted_ff <= nxt_muted;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_auxInit;
    $rose(rst_n) |-> fullScaleCode == 8'h7F;
  endproperty
  a_auxInit: assert property (p_auxInit) else $error("aux init");
  property p_auxWrite;
    wrAcc && paddr == ddsc_pkg::ADDR_AUX |=> fullScaleCode == $past(lowByte);
  endproperty
  a_auxWrite: assert property (p_auxWrite) else $error("aux write");
  property p_hold;
    dacValid && !dacReady |=> dacValid && $stable(dacData);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_start;
    $rose(rst_n) |-> ##[1:12] dacValid;
  endproperty
  a_start: assert property (p_start) else $error("no words");
  property p_mute;
    (muted_ff && dacReady) [*8] ##1 (muted_ff && dacReady) [*8]
      ##1 (muted_ff && dacReady) [*8] |-> dacData == 14'h0000;
  endproperty
  a_mute: assert property (p_mute) else $error("not muted");
  property p_ready;
    psel |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_errPhase;
    pslverr |-> psel && penable;
  endproperty
  a_errPhase: assert property (p_errPhase) else $error("stray error");
  property p_unmapped;
    psel && penable && !pwrite && paddr > 12'h014 |-> pslverr && !prdata;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind ddsc_core ddsc_monitor i_mon (.mclk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .dacData, .dacValid,
  .dacReady, .fullScaleCode);

//--- sim/ddsc_dac_model.sv
// Converter model taking sample words.
// The bench stalls it through stall.
`timescale 1ns/1ps
module ddsc_dac_model (
  input wire logic mclk,
  input wire logic stall,
  input wire logic [13:0] dacData,
  input wire logic dacValid,
  output logic dacReady,
  output logic [13:0] lastWord
);
  assign dacReady = !stall;
  always @(posedge mclk) begin
    if (dacValid && dacReady) begin
      lastWord <= dacData;
    end
  end
endmodule

//--- sim/tb.sv
// Bench for the DDS core with a converter model.
// One 40 MHz clock; APB driven at rising edges.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stall = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, a0;
  logic pready, pslverr, dacValid, dacReady, er;
  logic [13:0] dacData, lastWord;
  logic [7:0] fullScaleCode;
  int miscompares = 0;
  int check_count = 0;
  always #12.5 mclk = ~mclk;
  ddsc_core i_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dacData, .dacValid, .dacReady,
    .fullScaleCode);
  ddsc_dac_model i_dac (.mclk, .stall, .dacData, .dacValid, .dacReady,
    .lastWord);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_tones;
    logic [31:0] c [7] = '{32'h0, 32'h1_0000, 32'h0, 32'h1_0000, 32'h0,
      32'h0, 32'h40_0000};
    logic [15:0] p [7] = '{16'h0, 16'h0, 16'h4000, 16'h4000, 16'h0,
      16'h0, 16'h0};
    logic [13:0] a [7] = '{14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h3FFF,
      14'h2000, 14'h0, 14'h3FFF};
    int lo [7] = '{7800, -300, -300, 7800, 3900, 0, 5700};
    int hi [7] = '{8191, 300, 300, 8191, 4200, 0, 5900};
    int v;
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ddsc_pkg::ADDR_CTRL, c[i]);
      apb(1'b1, ddsc_pkg::ADDR_PHASE, {16'h0000, p[i]});
      apb(1'b1, ddsc_pkg::ADDR_AMP, {18'h0, a[i]});
      // Stall first so the buffer refuses, then settle
      stall <= 1'b1;
      repeat (10) @(posedge mclk);
      stall <= 1'b0;
      repeat (40) @(posedge mclk);
      v = $signed(lastWord);
      chk("tone", 1, v >= lo[i] && v <= hi[i]);
    end
  endtask
  task automatic t_aux;
    chk("aux reset", 32'h7F, fullScaleCode);
    apb(1'b1, ddsc_pkg::ADDR_AUX, 32'h0000_0025);
    @(posedge mclk);
    chk("aux pin", 32'h25, fullScaleCode);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h020, 32'h0);
    chk("unmapped write", 32'h1, er);
    apb(1'b0, ddsc_pkg::ADDR_AUX, 32'h0);
    chk("aux read", 32'h25, rd);
    chk("mapped", 32'h0, er);
  endtask
  task automatic t_accum(logic [31:0] f);
    apb(1'b1, ddsc_pkg::ADDR_FREQ, f);
    // New word reaches the accumulator only at the next 4-clock slot
    repeat (6) @(posedge mclk);
    apb(1'b0, ddsc_pkg::ADDR_STATUS, 32'h0);
    a0 = rd;
    apb(1'b0, ddsc_pkg::ADDR_STATUS, 32'h0);
    // Setup edges sit three clocks apart
    chk("step", 32'(f * 3), rd - a0);
  endtask
  task results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    results();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_tones();
    t_aux();
    t_accum(32'h1234_5678);
    t_accum(32'hFFFF_FFFF);
    results();
  end
endmodule
